// ### src/bou_dec_if.sv
/*
 * Decoded instruction fields passed from the decoder to the execute logic.
 * Assumes both ends sit in the same clock domain.
 */
`timescale 1ns/1ps
`include "bou_params.svh"

interface bou_dec_if;
    bou_pkg::bou_op_t op;
    logic [`BOU_ADDR_W-1:0] addr;
    logic [`BOU_BIT_W-1:0] bit_sel;

    modport dec (output op, output addr, output bit_sel);
    modport exe (input op, input addr, input bit_sel);
endinterface : bou_dec_if

// ### src/bou_decode.sv
/*
 * Pure decoder of one 14-bit program word into bit-op kind and operands.
 * Assumes the word is stable while the execute logic samples it.
 */
`timescale 1ns/1ps
`include "bou_params.svh"

module bou_decode (
    // Program word
    input wire logic [`BOU_WORD_W-1:0] word_i,
    // Decoded fields
    bou_dec_if.dec dec
);

    logic [`BOU_OPC_W-1:0] opc;

    always_comb begin
        opc = word_i[`BOU_OPC_LSB +: `BOU_OPC_W];
        dec.addr = word_i[`BOU_ADDR_LSB +: `BOU_ADDR_W];
        dec.bit_sel = word_i[`BOU_BIT_LSB +: `BOU_BIT_W];
        unique case (opc)
            `BOU_OPC_CLR: dec.op = bou_pkg::BOU_OP_CLR;
            `BOU_OPC_SET: dec.op = bou_pkg::BOU_OP_SET;
            `BOU_OPC_TST: dec.op = bou_pkg::BOU_OP_TST;
            default: dec.op = bou_pkg::BOU_OP_NONE;
        endcase
    end

endmodule : bou_decode

// ### src/bou_params.svh
/*
 * Constants of the bit-operation unit: word fields, opcodes, reset values, timing.
 * Assumes a 14-bit program word and a 128-byte data register file.
 */
// How it works
// - Every bit op word yields a 7-bit register address and 3-bit bit position.
// - Prefix 0100 clears the chosen bit; other bits kept; one cycle.
// - Prefix 0101 sets the chosen bit of the addressed register in one cycle.
// - Prefix 0110 reads the chosen bit; skip next instruction only if zero.
// - On a taken skip the prefetched word is discarded and alters nothing.
// - A taken skip adds a no-operation cycle; otherwise test takes one cycle.
`ifndef BOU_PARAMS_SVH
`define BOU_PARAMS_SVH

`define BOU_WORD_W 14
`define BOU_ADDR_W 7
`define BOU_BIT_W 3
`define BOU_DATA_W 8
`define BOU_REG_CNT 128

`define BOU_ADDR_LSB 0
`define BOU_BIT_LSB 7
`define BOU_OPC_LSB 10
`define BOU_OPC_W 4

`define BOU_OPC_CLR 4'h4
`define BOU_OPC_SET 4'h5
`define BOU_OPC_TST 4'h6

`define BOU_STATUS_ADDR 7'h03
`define BOU_FLAG_MASK 8'h07

`define BOU_REG_RST 8'h00
`define BOU_CYC_DIV 4

`endif

// ### src/bou_pkg.sv
/*
 * Types of the bit-operation unit.
 * Assumes bou_params.svh is on the include path.
 */
`include "bou_params.svh"

package bou_pkg;

    typedef enum logic [1:0] {
        BOU_OP_NONE = 2'b00,
        BOU_OP_CLR = 2'b01,
        BOU_OP_SET = 2'b10,
        BOU_OP_TST = 2'b11
    } bou_op_t;

endpackage : bou_pkg

// ### src/bou_unit.sv
/*
 * Bit-operation unit: executes clear, set and test-and-skip on a flop register file.
 * Assumes a new prefetched word is presented with instr_valid_i each instruction cycle.
 */
`timescale 1ns/1ps
`include "bou_params.svh"

module bou_unit #(
    parameter int CYC_DIV = `BOU_CYC_DIV
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Prefetched program word
    input wire logic instr_valid_i,
    input wire logic [`BOU_WORD_W-1:0] instr_i,
    // Load port for other instructions
    input wire logic ld_we_i,
    input wire logic [`BOU_ADDR_W-1:0] ld_addr_i,
    input wire logic [`BOU_DATA_W-1:0] ld_data_i,
    // Read port
    input wire logic [`BOU_ADDR_W-1:0] rd_addr_i,
    output logic [`BOU_DATA_W-1:0] rd_data_o,
    // Execute status
    output logic cyc_o,
    output logic exec_valid_o,
    output logic [1:0] exec_op_o,
    output logic [`BOU_ADDR_W-1:0] exec_addr_o,
    output logic [`BOU_BIT_W-1:0] exec_bit_o,
    output logic test_bit_o,
    output logic skip_pend_o,
    output logic nop_o
);

    localparam int DIV_W = (CYC_DIV > 1) ? $clog2(CYC_DIV) : 1;
    // Sampled clocks from an executed test to the next instruction-cycle edge
    localparam int SKIP_GAP = CYC_DIV - 1;

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic cyc;
        logic skip_pend;
        logic [`BOU_REG_CNT-1:0][`BOU_DATA_W-1:0] regs;
        logic [`BOU_DATA_W-1:0] rd_data;
        logic ex_valid;
        bou_pkg::bou_op_t ex_op;
        logic [`BOU_ADDR_W-1:0] ex_addr;
        logic [`BOU_BIT_W-1:0] ex_bit;
        logic tbit;
        logic no_operation_op;
        logic [`BOU_DATA_W-1:0] pre_byte;
    } bou_state_t;

    bou_state_t st_r;
    bou_state_t st_nxt;
    logic cyc_en;

    bou_dec_if dec_if ();

    bou_decode u_dec (
        .word_i(instr_i),
        .dec(dec_if.dec)
    );

    // ****************************************************
    // Next state
    // ****************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.ex_valid = 1'b0;
        st_nxt.no_operation_op = 1'b0;
        cyc_en = (st_r.div == DIV_W'(CYC_DIV - 1));
        st_nxt.div = cyc_en ? '0 : DIV_W'(st_r.div + 1'b1);
        st_nxt.cyc = cyc_en;
        if (ld_we_i) begin
            st_nxt.regs[ld_addr_i] = ld_data_i;
        end
        if (cyc_en && instr_valid_i) begin
            if (st_r.skip_pend) begin
                // Prefetched word dropped; the pending flag clears and the no-operation flag is raised
                st_nxt.skip_pend = 1'b0;
                st_nxt.no_operation_op = 1'b1;
            end else begin
                st_nxt.ex_valid = 1'b1;
                st_nxt.ex_op = dec_if.op;
                st_nxt.ex_addr = dec_if.addr;
                st_nxt.ex_bit = dec_if.bit_sel;
                st_nxt.pre_byte = st_nxt.regs[dec_if.addr];
                // Only the chosen bit is touched, so flags move only when addressed
                unique case (dec_if.op)
                    bou_pkg::BOU_OP_CLR: st_nxt.regs[dec_if.addr][dec_if.bit_sel] = 1'b0;
                    bou_pkg::BOU_OP_SET: st_nxt.regs[dec_if.addr][dec_if.bit_sel] = 1'b1;
                    bou_pkg::BOU_OP_TST: begin
                        st_nxt.tbit = st_r.regs[dec_if.addr][dec_if.bit_sel];
                        st_nxt.skip_pend = ~st_r.regs[dec_if.addr][dec_if.bit_sel];
                    end
                    bou_pkg::BOU_OP_NONE: begin
                    end
                endcase
            end
        end
        st_nxt.rd_data = st_nxt.regs[rd_addr_i];
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data_o = st_r.rd_data;
    assign cyc_o = st_r.cyc;
    assign exec_valid_o = st_r.ex_valid;
    assign exec_op_o = st_r.ex_op;
    assign exec_addr_o = st_r.ex_addr;
    assign exec_bit_o = st_r.ex_bit;
    assign test_bit_o = st_r.tbit;
    assign skip_pend_o = st_r.skip_pend;
    assign nop_o = st_r.no_operation_op;

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence s_skip_taken;
        st_r.ex_valid && st_r.ex_op == bou_pkg::BOU_OP_TST && !st_r.tbit;
    endsequence

    sequence s_discard;
        st_r.skip_pend && cyc_en && instr_valid_i;
    endsequence

    field_take_a: assert property (st_r.ex_valid |-> st_r.ex_addr == $past(instr_i[6:0])
        && st_r.ex_bit == $past(instr_i[9:7]))
        else $error("operand fields not taken from word");
    clear_bit_a: assert property (st_r.ex_valid && st_r.ex_op == bou_pkg::BOU_OP_CLR
        |-> st_r.regs[st_r.ex_addr][st_r.ex_bit] == 1'b0)
        else $error("clear left bit set");
    set_bit_a: assert property (st_r.ex_valid && st_r.ex_op == bou_pkg::BOU_OP_SET
        |-> st_r.regs[st_r.ex_addr][st_r.ex_bit] == 1'b1)
        else $error("set left bit clear");
    other_bits_a: assert property (st_r.ex_valid && $past(!ld_we_i)
        |-> ((st_r.regs[st_r.ex_addr] ^ st_r.pre_byte) & ~(8'h01 << st_r.ex_bit)) == 8'h00)
        else $error("bit op changed other bits");
    skip_arm_a: assert property (st_r.ex_valid && st_r.ex_op == bou_pkg::BOU_OP_TST
        |-> st_r.skip_pend == !st_r.tbit)
        else $error("skip decision wrong");
    discard_a: assert property (s_discard ##0 !ld_we_i |=> st_r.regs == $past(st_r.regs)
        && !st_r.ex_valid)
        else $error("discarded word altered state");
    skip_nop_a: assert property (s_skip_taken ##SKIP_GAP s_discard
        |=> st_r.no_operation_op && !st_r.skip_pend)
        else $error("no nop after taken skip");
    flags_kept_a: assert property (st_r.ex_valid && st_r.ex_addr != `BOU_STATUS_ADDR
        && $past(!ld_we_i) |-> (st_r.regs[`BOU_STATUS_ADDR] & `BOU_FLAG_MASK)
        == ($past(st_r.regs[`BOU_STATUS_ADDR]) & `BOU_FLAG_MASK))
        else $error("status flags disturbed");

endmodule : bou_unit

// ### test/bou_fetch_model.sv
/* Fetch-path model: presents one prefetched word per instruction cycle.
   Assumes cyc_i is the unit's pulse after each instruction-cycle edge. */
`timescale 1ns/1ps
`include "bou_params.svh"

module bou_fetch_model (
    // Clock and unit status
    input wire logic clk_sys_i,
    input wire logic cyc_i,
    // Prefetched word
    output logic instr_valid_o,
    output logic [`BOU_WORD_W-1:0] instr_o
);
    initial begin
        instr_valid_o = 1'b0;
        instr_o = 14'h0000;
    end

    // Called at a falling edge; returns at the falling edge after the word was taken
    // A missing cycle pulse hangs here and is caught by the bench's timeout
    task automatic fetch(input logic [`BOU_WORD_W-1:0] w);
        instr_valid_o = 1'b1;
        instr_o = w;
        do begin
            @(negedge clk_sys_i);
        end while (cyc_i !== 1'b1);
    endtask : fetch

    task automatic idle();
        instr_valid_o = 1'b0;
        // Released path must not look like the old word
        instr_o = ~instr_o;
    endtask : idle
endmodule : bou_fetch_model

// ### test/test_bit_op_instruction_unit.sv
/* Self-checking bench of the bit-operation unit.
   Assumes bou_pkg and bou_params.svh are compiled and on the include path. */
`timescale 1ns/1ps
`include "bou_params.svh"

module test_bit_op_instruction_unit;
    logic clk_sys_i = 1'b0, rst_i = 1'b1, ld_we_i = 1'b0, iv, cyc, ev, tb, sp, no_operation_op;
    logic [13:0] iw;
    logic [6:0] ld_addr_i = 7'h00, rd_addr_i = 7'h00, ea;
    logic [7:0] ld_data_i = 8'h00, rd;
    logic [2:0] eb;
    logic [1:0] eo;
    int bad_count = 0, checked = 0, cycles = 0;

    bou_fetch_model fm (.clk_sys_i(clk_sys_i), .cyc_i(cyc), .instr_valid_o(iv), .instr_o(iw));
    bou_unit #(.CYC_DIV(2)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .instr_valid_i(iv),
        .instr_i(iw), .ld_we_i(ld_we_i), .ld_addr_i(ld_addr_i), .ld_data_i(ld_data_i),
        .rd_addr_i(rd_addr_i), .rd_data_o(rd), .cyc_o(cyc), .exec_valid_o(ev), .exec_op_o(eo),
        .exec_addr_o(ea), .exec_bit_o(eb), .test_bit_o(tb), .skip_pend_o(sp), .nop_o(no_operation_op));

    initial forever #10 clk_sys_i = ~clk_sys_i;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [13:0] w(logic [3:0] op, logic [2:0] b, logic [6:0] a);
        return {op, b, a};
    endfunction : w

    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic ld(logic [6:0] a, logic [7:0] d);
        ld_we_i = 1'b1;
        ld_addr_i = a;
        ld_data_i = d;
        @(negedge clk_sys_i);
        ld_we_i = 1'b0;
    endtask : ld

    task automatic rdc(string what, logic [6:0] a, logic [7:0] exp);
        rd_addr_i = a;
        @(negedge clk_sys_i);
        chk(what, exp, rd);
    endtask : rdc

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_clear();
        ld(7'h7F, 8'hC7);
        fm.fetch(w(4'h4, 3'h7, 7'h7F));
        chk("clr op", 8'h01, {6'h00, eo});
        chk("clr fld", 8'hFF, {ea, 1'b1} & {eb, 5'h1F});
        fm.idle();
        rdc("clr reg", 7'h7F, 8'h47);
    endtask : t_clear

    task automatic t_skip();
        ld(7'h20, 8'h7D);
        ld(7'h21, 8'h00);
        fm.fetch(w(4'h6, 3'h1, 7'h20));
        chk("tst pend", 8'h03, {6'h00, ev, sp});
        fm.fetch(w(4'h5, 3'h0, 7'h21));
        chk("skip nop", 8'h02, {6'h00, no_operation_op, ev});
        fm.fetch(w(4'h5, 3'h1, 7'h21));
        chk("after", 8'h01, {6'h00, no_operation_op, ev});
        fm.fetch(w(4'h6, 3'h6, 7'h20));
        chk("noskip", 8'h02, {6'h00, tb, sp});
        fm.fetch(w(4'h5, 3'h2, 7'h21));
        chk("next", 8'h01, {6'h00, no_operation_op, ev});
        fm.idle();
        rdc("discard", 7'h21, 8'h06);
    endtask : t_skip

    task automatic t_flags();
        ld(7'h03, 8'h07);
        fm.fetch(w(4'h5, 3'h7, 7'h03));
        chk("set op", 8'h02, {6'h00, eo});
        fm.fetch(w(4'h5, 3'h0, 7'h00));
        // A word of another instruction must execute as no bit op
        fm.fetch(w(4'h7, 3'h0, 7'h00));
        chk("other op", 8'h04, {5'h00, ev, eo});
        fm.idle();
        rdc("status", 7'h03, 8'h87);
        rdc("set reg", 7'h00, 8'h01);
    endtask : t_flags

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            wrap_up();
        end
    end

    initial begin
        repeat (8) @(negedge clk_sys_i);
        rst_i = 1'b0;
        t_clear();
        t_skip();
        t_flags();
        wrap_up();
    end
endmodule : test_bit_op_instruction_unit
